// ---- tb_top.sv ----
// self-checking bench joining both ends of the translator
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  fail_count++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
  import uhr_pkg::*;
  logic        ref_clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        hid_valid_o, hid_last_o, hid_ready_i, connected_i;
  logic        disconnect_o, lock_valid_i, lock_num_i, lock_caps_i;
  logic        lock_scroll_i;
  logic [7:0]  wb_adr_i, hid_data_o, b;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, seed, q, v;
  logic [7:0]  hid_q[$], exp_q[$];
  int          fail_count, cmp_count, disc_n, i, last_n, exp_l;
  uhr_link_if link ();
  uhr_mcu_end u_uhr_mcu_end (.ref_clk_i, .reset_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .link(link));
  uhr_dev_end #(.HOLD_CYC(20)) u_uhr_dev_end (.ref_clk_i, .reset_i,
    .hid_data_o, .hid_valid_o, .hid_last_o, .hid_ready_i, .connected_i,
    .disconnect_o, .lock_valid_i, .lock_num_i, .lock_caps_i,
    .lock_scroll_i, .link(link));
  uhr_link_properties u_uhr_link_properties (.ref_clk_i, .reset_i,
    .rx_data(link.rx_data), .tx_data(link.tx_data),
    .rx_valid(link.rx_valid), .rx_ready(link.rx_ready),
    .tx_valid(link.tx_valid), .tx_ready(link.tx_ready),
    .keyboard_toggle_pin(link.keyboard_toggle_pin), .ks_we(link.ks_we),
    .flag_we(link.flag_we), .flag_vkbd(link.flag_vkbd),
    .vkbd_en(link.vkbd_en), .ks_wdata(link.ks_wdata),
    .ks_rdata(link.ks_rdata));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] key_of(input logic [7:0] k);
    if (k >= 8'h61 && k <= 8'h7A) return {8'h00, k - 8'h5D};
    if (k >= 8'h41 && k <= 8'h5A) return {8'h02, k - 8'h3D};
    if (k >= 8'h0F && k <= 8'h1A) return {8'h00, k + 8'h2B};
    if (k >= 8'hE0 && k <= 8'hE7) return {8'h01 << (k - 8'hE0), 8'h00};
    if (k >= 8'h80 && k <= 8'hDF) return {8'h00, k};
    case (k)
      8'h01: return 16'h0049;
      8'h08: return 16'h002A;
      8'h0A, 8'h0D: return 16'h0028;
      8'h20: return 16'h002C;
      8'h7F: return 16'h0065;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [7:0] pick(input int n);
    logic [31:0] r;
    r = rnd();
    case (n)
      0: return 8'hE1;
      1: return 8'h7F;
      2: return 8'h1A;
      3: return 8'h0D;
      4: return 8'h41;
      default: case (r[2:0])
        0: return 8'h61 + 8'(r[15:8] % 26);
        1: return 8'h41 + 8'(r[15:8] % 26);
        2: return 8'h80 + 8'(r[15:8] % 96);
        3: return 8'h0F + 8'(r[15:8] % 12);
        4: return 8'hE0 + 8'(r[10:8]);
        5: return 8'h20;
        6: return 8'h08;
        default: return 8'h01;
      endcase
    endcase
  endfunction
  task automatic wb(input logic we, input logic [7:0] a, input int d);
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge ref_clk_i);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic poll(input int bit_i, input logic want);
    do wb(1'b0, ADR_STATUS, 0); while (q[bit_i] !== want);
  endtask
  task automatic send(input logic [7:0] k);
    poll(ST_TX_BUSY, 1'b0);
    wb(1'b1, ADR_TX, {24'h0, k});
  endtask
  task automatic rd_rx();
    poll(ST_RX_FULL, 1'b1);
    wb(1'b0, ADR_RX, 0);
  endtask
  task automatic exp_key(input logic [7:0] k);
    logic [15:0] m;
    m = key_of(k);
    exp_q = {exp_q, 8'h09, 8'h01, m[15:8], 8'h00, m[7:0]};
    repeat (5) exp_q.push_back(8'h00);
    exp_q = {exp_q, 8'h09, 8'h01};
    repeat (8) exp_q.push_back(8'h00);
    exp_l += 2;
  endtask
  task automatic wait_chk(input string n);
    for (int k = 0; k < 2000 && hid_q.size() < exp_q.size(); k++)
      @(posedge ref_clk_i);
    repeat (30) @(posedge ref_clk_i);
    `CHK(n, exp_q.size(), hid_q.size())
    `CHK(n, exp_l, last_n)
    foreach (exp_q[j]) if (j < hid_q.size()) `CHK(n, exp_q[j], hid_q[j])
    hid_q.delete();
    exp_q.delete();
    {last_n, exp_l} = 64'h0;
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (hid_valid_o && hid_ready_i) hid_q.push_back(hid_data_o);
    if (hid_valid_o && hid_ready_i && hid_last_o) last_n++;
    if (disconnect_o === 1'b1) disc_n++;
    hid_ready_i <= (rnd() & 32'h3) != 0;
  end
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    fail_count++;
    complete_run();
  end
  initial begin
    seed = 32'd80210;
    {wb_cyc_i, wb_stb_i, wb_we_i, connected_i, lock_valid_i} = 5'h00;
    {lock_num_i, lock_caps_i, lock_scroll_i} = 3'h0;
    {wb_adr_i, wb_dat_i, wb_sel_i} = {8'h00, 32'h0, 4'hF};
    reset_i = 1'b1;
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    wb(1'b0, ADR_KEYSUB, 0);
    `CHK("keysub reset", 32'h0, q)
    wb(1'b0, ADR_CTRL, 0);
    `CHK("enable reset", 1'b0, q[CTRL_VKBD])
    wb(1'b0, 8'h20, 0);
    `CHK("unmapped read", 32'h0, q)
    for (i = 0; i < 24; i++) begin
      b = pick(i);
      send(b);
      exp_key(b);
      wait_chk("key report");
    end
    wb(1'b1, ADR_KEYSUB, 32'h1011);
    wb(1'b0, ADR_KEYSUB, 0);
    `CHK("keysub readback", 32'h1011, q)
    for (i = 0; i < 10; i++)
      send(8'(80'hFD03031000FD03030000 >> (72 - 8 * i)));
    exp_q = {8'h03, 8'h03, 8'h10, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00};
    exp_l = 2;
    wait_chk("consumer frame");
    send(8'h10);
    exp_key(8'h11);
    wait_chk("substituted key");
    wb(1'b1, ADR_KEYSUB, 32'h5A00);
    connected_i <= 1'b1;
    send(8'h5A);
    wait_chk("no report on drop");
    `CHK("drop pulse", 1, disc_n)
    connected_i <= 1'b0;
    send(8'h00);
    wait_chk("no report idle");
    `CHK("no drop idle", 1, disc_n)
    wb(1'b1, ADR_KEYSUB, 0);
    send(8'h5A);
    exp_key(8'h5A);
    wait_chk("substitution off");
    for (i = 0; i < 5; i++) begin
      if (i < 4) begin
        v = rnd();
        @(posedge ref_clk_i);
        {lock_scroll_i, lock_caps_i, lock_num_i} <= v[2:0];
        lock_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        lock_valid_i <= 1'b0;
      end else send(8'hFF);
      rd_rx();
      `CHK("out code", 8'hFF, q[7:0])
      rd_rx();
      `CHK("lock status", {5'h00, v[2:0]}, q[7:0])
    end
    for (i = 0; i < 3; i++) begin
      wb(1'b1, ADR_CTRL, i == 2 ? 32'h0 : 32'h2);
      wb(1'b1, ADR_CTRL, i == 2 ? 32'h1 : 32'h3);
      repeat (i == 1 ? 5 : 40) @(posedge ref_clk_i);
      wb(1'b1, ADR_CTRL, 32'h0);
      if (i == 0) exp_key(8'h7F);
      wait_chk("toggle pin");
    end
    complete_run();
  end
endmodule
`default_nettype wire

// ---- uhr_dev_end.sv ----
// translator end: uart bytes in, hid reports out, lock status back
// What this block does
// R01: lock change sends 0xFF plus status byte
// R02: status bits: num 1, caps 2, scroll 4
// R03: toggle pin held high at least 200 ms
// R04: toggle pin acts only when enabled
// R05: nonzero substitution replaces upper byte by lower
// R06: substitution resets to zero; zero disables
// R07: substitution written and read via link
// R08: zero byte drops connection, no report
// R09: substitution applied before disconnect check
// R10: consumer frame FD 3 3 low high
// R11: consumer bitmask passes through, bits unchanged
// R12: host releases consumer keys with zeros
// R13: control bytes map to fixed key codes
// R14: printable bytes via table, shift for upper
// R15: byte 127 sends key code 0x65
// R16: scan codes pass, E0-E7 are modifiers
// R17: F0-FC reserved, FD raw, FE shorthand, FF output
// R18: press report then release report
// R19: keyboard frame 9, 1, mod, 0, six codes
// R20: modifier bits left 0-3, right 4-7
// R21: substitution only on single-key bytes
//
// The placing of the registers and the Wishbone register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module uhr_dev_end #(
  parameter int DEPTH    = 16,
  parameter int HOLD_CYC = uhr_pkg::TOGGLE_HOLD_CYC
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  // radio side
  output logic      [7:0] hid_data_o,
  output logic            hid_valid_o,
  output logic            hid_last_o,
  input  wire logic       hid_ready_i,
  input  wire logic       connected_i,
  output logic            disconnect_o,
  // lock state from host
  input  wire logic       lock_valid_i,
  input  wire logic       lock_num_i,
  input  wire logic       lock_caps_i,
  input  wire logic       lock_scroll_i,
  // link
  uhr_link_if.dev         link
);
  import uhr_pkg::*;
  localparam int IW = $clog2(DEPTH);
  localparam int CW = $clog2(HOLD_CYC + 1);
  localparam logic [CW-1:0] HOLD_END = CW'(HOLD_CYC - 1);
  localparam logic [IW-1:0] DEPTH_M1 = IW'(DEPTH - 1);

  uhr_state_t     state;
  uhr_state_t     next_state;
  uhr_tx_t        txs;
  logic [7:0]     buffer [DEPTH];
  logic [7:0]     cnt;
  logic [7:0]     need;
  logic [IW-1:0]  n_emit;
  logic [IW:0]    idx;
  logic           rel_pend;
  logic [15:0]    keysub;
  logic [2:0]     lock_st;
  logic           out_req;
  logic           pin_q;
  logic           armed;
  logic [CW-1:0]  hold_cnt;
  logic           vk_req;

  wire       rx_fire = link.rx_valid && link.rx_ready;
  // single-key bytes only; frame bytes bypass the substitution
  wire       sub_hit = keysub != KEYSUB_RST && link.rx_data == keysub[15:8];
  wire [7:0] key     = sub_hit ? keysub[7:0] : link.rx_data; // R05 R21
  wire       is_ctl  = key != BYTE_DISC && key <= BYTE_CTL_LAST;
  wire       is_prn  = key > BYTE_CTL_LAST && key <= BYTE_PR_LAST;
  wire       is_mod  = key >= BYTE_MOD_LO && key <= BYTE_MOD_HI;
  wire       is_rsv  = key >= BYTE_RSV_LO && key <= BYTE_RSV_HI;
  wire [8:0] prn     = uhr_prn_code(key);
  wire [7:0] mod_bit = 8'(8'h01 << key[2:0]); // R16 R20
  wire [7:0] k_code  = is_ctl ? uhr_ctl_code(key) : // R13
                       is_prn ? prn[7:0] : // R14
                       key == BYTE_DEL ? CODE_VKBD : // R15
                       is_mod ? 8'h00 : key; // R16
  wire [7:0] k_mod   = is_mod ? mod_bit :
                       (is_prn && prn[8]) ? MOD_LSHIFT : 8'h00; // R14
  wire       k_any   = k_code != 8'h00 || k_mod != 8'h00;
  wire       is_key  = key != BYTE_DISC && !is_rsv && key != BYTE_RAW &&
                       key != BYTE_SHORT && key != BYTE_OUTREP;
  wire [7:0] lock_in = {5'h00, lock_scroll_i, lock_caps_i, lock_num_i}; // R02
  wire [7:0] sh_pos  = cnt == 8'h00 ? 8'(KB_MOD_POS) :
                       8'(cnt + 8'(KB_CODE_POS) - 8'h01);
  wire       emit_ok = !hid_valid_o || hid_ready_i;
  wire       emit_dn = idx == {1'b0, n_emit};
  wire [IW-1:0] raw_n = (need >= 8'(DEPTH - 1)) ? DEPTH_M1 : IW'(need) + 1'b1;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (rx_fire && key == BYTE_RAW) begin
          next_state = ST_RAW_LEN; // R17
        end else if (rx_fire && key == BYTE_SHORT) begin
          next_state = ST_SH_LEN; // R17
        end else if ((rx_fire && is_key && k_any) || (!rx_fire && vk_req)) begin
          next_state = ST_SEND;
        end
      end
      ST_RAW_LEN:  if (rx_fire) next_state = link.rx_data == 8'h00 ?
                                             ST_SEND : ST_RAW_DATA;
      ST_RAW_DATA: if (rx_fire && cnt == need) next_state = ST_SEND;
      ST_SH_LEN:   if (rx_fire) next_state = link.rx_data == 8'h00 ?
                                             ST_SEND : ST_SH_DATA;
      ST_SH_DATA:  if (rx_fire && cnt == 8'(need - 8'h01)) next_state = ST_SEND;
      ST_SEND:     if (emit_ok && emit_dn && !rel_pend) next_state = ST_IDLE;
      default:     next_state = ST_IDLE;
    endcase
  end

  task automatic kb_clear();
    for (int i = 0; i < KB_FRAME_N; i++) buffer[i] <= 8'h00;
    buffer[0] <= KB_LEN; // R19
    buffer[1] <= KB_DESC; // R19
  endtask

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state       <= ST_IDLE;
      link.rx_ready <= 1'b0;
      hid_valid_o <= 1'b0;
      hid_data_o  <= 8'h00;
      hid_last_o  <= 1'b0;
      disconnect_o <= 1'b0;
      cnt         <= 8'h00;
      need        <= 8'h00;
      n_emit      <= '0;
      idx         <= '0;
      rel_pend    <= 1'b0;
      for (int i = 0; i < DEPTH; i++) buffer[i] <= 8'h00;
    end else begin
      state         <= next_state;
      link.rx_ready <= next_state != ST_SEND;
      disconnect_o  <= rx_fire && state == ST_IDLE && key == BYTE_DISC &&
                       connected_i; // R08 R09
      case (state)
        ST_IDLE: begin
          idx <= '0;
          if (rx_fire && key == BYTE_SHORT) begin
            kb_clear();
          end else if (rx_fire && is_key && k_any) begin
            kb_clear();
            buffer[KB_MOD_POS]  <= k_mod;
            buffer[KB_CODE_POS] <= k_code;
            n_emit   <= KB_FRAME_N;
            rel_pend <= 1'b1; // R18
          end else if (!rx_fire && vk_req) begin
            kb_clear();
            buffer[KB_CODE_POS] <= CODE_VKBD; // R04
            n_emit   <= KB_FRAME_N;
            rel_pend <= 1'b1; // R18
          end
        end
        ST_RAW_LEN: if (rx_fire) begin
          // start byte stripped, length and body forwarded untouched
          buffer[0] <= link.rx_data; // R10 R11 R12
          need      <= link.rx_data;
          cnt       <= 8'h01;
          n_emit    <= IW'(1);
        end
        ST_RAW_DATA: if (rx_fire) begin
          // bytes beyond the buffer are dropped
          if (cnt < 8'(DEPTH)) buffer[cnt[IW-1:0]] <= link.rx_data;
          cnt    <= 8'(cnt + 8'h01);
          n_emit <= raw_n;
        end
        ST_SH_LEN: if (rx_fire) begin
          need   <= link.rx_data;
          cnt    <= 8'h00;
          n_emit <= KB_FRAME_N;
        end
        ST_SH_DATA: if (rx_fire) begin
          if (cnt <= SH_MAX_IDX) buffer[sh_pos[IW-1:0]] <= link.rx_data;
          cnt <= 8'(cnt + 8'h01);
        end
        ST_SEND: if (emit_ok) begin
          if (!emit_dn) begin
            hid_valid_o <= 1'b1;
            hid_data_o  <= buffer[idx[IW-1:0]];
            hid_last_o  <= idx == {1'b0, n_emit} - 1'b1;
            idx         <= idx + 1'b1;
          end else begin
            hid_valid_o <= 1'b0;
            hid_last_o  <= 1'b0;
            idx         <= '0;
            if (rel_pend) begin
              rel_pend <= 1'b0;
              kb_clear(); // R18
            end
          end
        end
        default: ;
      endcase
    end
  end

  // substitution value and enable flag
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      keysub        <= KEYSUB_RST; // R06
      link.ks_rdata <= KEYSUB_RST;
      link.vkbd_en  <= 1'b0;
    end else begin
      if (link.ks_we) keysub <= link.ks_wdata; // R07
      link.ks_rdata <= link.ks_we ? link.ks_wdata : keysub; // R07
      if (link.flag_we) link.vkbd_en <= link.flag_vkbd;
    end
  end

  // toggle pin: rising edge, then a full hold before one request
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pin_q    <= 1'b0;
      armed    <= 1'b0;
      hold_cnt <= '0;
      vk_req   <= 1'b0;
    end else begin
      pin_q <= link.keyboard_toggle_pin;
      if (!link.keyboard_toggle_pin || !link.vkbd_en) begin
        armed    <= 1'b0; // R04
        hold_cnt <= '0;
      end else if (!pin_q) begin
        armed    <= 1'b1;
        hold_cnt <= '0;
      end else if (armed && hold_cnt != HOLD_END) begin
        hold_cnt <= hold_cnt + 1'b1; // R03
      end
      if (armed && hold_cnt == HOLD_END && link.vkbd_en) begin
        vk_req <= 1'b1; // R04
        armed  <= 1'b0;
      end else if (state == ST_IDLE && !rx_fire) begin
        vk_req <= 1'b0;
      end
    end
  end

  // output report back to the microcontroller
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      txs           <= TX_IDLE;
      lock_st       <= 3'h0;
      out_req       <= 1'b0;
      link.tx_valid <= 1'b0;
      link.tx_data  <= 8'h00;
    end else begin
      if (lock_valid_i) lock_st <= lock_in[2:0];
      case (txs)
        TX_IDLE: if (out_req) begin
          link.tx_valid <= 1'b1;
          link.tx_data  <= BYTE_OUTREP; // R01
          txs           <= TX_CODE;
        end
        TX_CODE: if (link.tx_ready) begin
          link.tx_data <= {5'h00, lock_st}; // R01 R02
          txs          <= TX_STAT;
        end
        TX_STAT: if (link.tx_ready) begin
          link.tx_valid <= 1'b0;
          txs           <= TX_IDLE;
        end
        default: txs <= TX_IDLE;
      endcase
      // a new event in the cycle the request is taken wins
      if (lock_valid_i || (rx_fire && state == ST_IDLE &&
                           key == BYTE_OUTREP)) begin
        out_req <= 1'b1; // R01 R17
      end else if (txs == TX_IDLE) begin
        out_req <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- uhr_link_if.sv ----
// link between the microcontroller end and the translator end
`timescale 1ns/100ps
`default_nettype none
interface uhr_link_if;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic        keyboard_toggle_pin;
  logic        ks_we;
  logic [15:0] ks_wdata;
  logic [15:0] ks_rdata;
  logic        flag_we;
  logic        flag_vkbd;
  logic        vkbd_en;
  modport dev (input rx_data, rx_valid, tx_ready, keyboard_toggle_pin,
               ks_we, ks_wdata, flag_we, flag_vkbd,
               output rx_ready, tx_data, tx_valid, ks_rdata, vkbd_en);
  modport mcu (output rx_data, rx_valid, tx_ready, keyboard_toggle_pin,
               ks_we, ks_wdata, flag_we, flag_vkbd,
               input rx_ready, tx_data, tx_valid, ks_rdata, vkbd_en);
endinterface
`default_nettype wire

// ---- uhr_link_properties.sv ----
// concurrent checks on the link between the two translator ends
`timescale 1ns/100ps
`default_nettype none
module uhr_link_properties (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic [7:0]  rx_data,
  input wire logic [7:0]  tx_data,
  input wire logic        rx_valid, rx_ready, tx_valid, tx_ready,
  input wire logic        keyboard_toggle_pin, ks_we, flag_we,
  input wire logic        flag_vkbd, vkbd_en,
  input wire logic [15:0] ks_wdata, ks_rdata
);
  logic last_flag;
  always_ff @(posedge ref_clk_i) begin
    if (flag_we) begin
      last_flag <= flag_vkbd;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  a_ks_reset_zero: assert property (disable iff (1'b0)
    reset_i |=> ks_rdata == 16'h0000 && !vkbd_en)
    else $error("substitution or enable not cleared by reset");
  a_ks_write_lands: assert property (ks_we |=>
    ks_rdata == $past(ks_wdata)) else $error("substitution write lost");
  a_ks_held_still: assert property (!ks_we |=> $stable(ks_rdata))
    else $error("substitution changed without a write");
  a_out_code_first: assert property ($rose(tx_valid) |->
    tx_data == 8'hFF) else $error("output report not opened by FF");
  a_out_status_next: assert property (
    tx_valid && tx_ready && tx_data == 8'hFF |=>
    tx_valid && tx_data[7:3] == 5'h00) else $error("bad status byte");
  a_tx_byte_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("tx byte not held");
  a_rx_byte_hold: assert property (rx_valid && !rx_ready |=>
    rx_valid && $stable(rx_data)) else $error("rx byte not held");
  a_rx_taken_drop: assert property (rx_valid && rx_ready |=> !rx_valid)
    else $error("rx valid stayed after taking");
  a_vkbd_follows: assert property (flag_we |=> ##[0:1]
    vkbd_en == last_flag) else $error("toggle enable not applied");
  c_ks_write: cover property (ks_we ##1 ks_rdata != 16'h0000);
  c_out_report: cover property (tx_valid && tx_ready && tx_data == 8'hFF);
  c_vkbd_on: cover property (vkbd_en && $rose(keyboard_toggle_pin));
endmodule
`default_nettype wire

// ---- uhr_mcu_end.sv ----
// microcontroller end: wishbone registers driving the translator link
`timescale 1ns/100ps
`default_nettype none
module uhr_mcu_end (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // link
  uhr_link_if.mcu          link
);
  import uhr_pkg::*;

  logic [7:0] rx_byte;
  logic       rx_full;
  logic       ctrl_pin;

  wire req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr      = req && wb_we_i;
  wire rd      = req && !wb_we_i;
  wire hit_tx  = wb_adr_i == ADR_TX;
  wire hit_rx  = wb_adr_i == ADR_RX;
  wire hit_st  = wb_adr_i == ADR_STATUS;
  wire hit_ks  = wb_adr_i == ADR_KEYSUB;
  wire hit_ctl = wb_adr_i == ADR_CTRL;
  wire tx_fire = link.rx_valid && link.rx_ready;
  wire in_fire = link.tx_valid && link.tx_ready;
  wire [15:0] ks_merge = {wb_sel_i[1] ? wb_dat_i[15:8] : link.ks_rdata[15:8],
                          wb_sel_i[0] ? wb_dat_i[7:0] : link.ks_rdata[7:0]};
  wire [31:0] st_word  = {30'h0, rx_full, link.rx_valid};
  wire [31:0] ctl_word = {30'h0, link.vkbd_en, ctrl_pin};
  wire [31:0] rd_word  = hit_rx  ? {24'h0, rx_byte} :
                         hit_st  ? st_word :
                         hit_ks  ? {16'h0, link.ks_rdata} :
                         hit_ctl ? ctl_word : 32'h0;

  assign link.keyboard_toggle_pin = ctrl_pin;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h0;
      link.rx_valid  <= 1'b0;
      link.rx_data   <= 8'h00;
      link.tx_ready  <= 1'b0;
      link.ks_we     <= 1'b0;
      link.ks_wdata  <= KEYSUB_RST;
      link.flag_we   <= 1'b0;
      link.flag_vkbd <= 1'b0;
      rx_byte        <= 8'h00;
      rx_full        <= 1'b0;
      ctrl_pin       <= 1'b0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= rd ? rd_word : 32'h0;
      if (wr && hit_tx && wb_sel_i[0] && !link.rx_valid) begin
        link.rx_valid <= 1'b1;
        link.rx_data  <= wb_dat_i[7:0];
      end else if (tx_fire) begin
        link.rx_valid <= 1'b0;
      end
      if (in_fire) begin
        rx_byte <= link.tx_data;
        rx_full <= 1'b1;
      end else if (rd && hit_rx) begin
        rx_full <= 1'b0;
      end
      link.tx_ready <= !rx_full && !in_fire;
      link.ks_we    <= wr && hit_ks; // R07
      link.ks_wdata <= ks_merge;
      link.flag_we  <= wr && hit_ctl && wb_sel_i[0];
      if (wr && hit_ctl && wb_sel_i[0]) begin
        // software keeps the pin high long enough for the toggle
        ctrl_pin       <= wb_dat_i[CTRL_PIN]; // R03
        link.flag_vkbd <= wb_dat_i[CTRL_VKBD];
      end
    end
  end
endmodule
`default_nettype wire

// ---- uhr_pkg.sv ----
// shared constants, types and lookup functions for the hid report translator
package uhr_pkg;
  localparam logic [7:0] BYTE_DISC     = 8'h00;
  localparam logic [7:0] BYTE_DEL      = 8'h7F;
  localparam logic [7:0] BYTE_CTL_LAST = 8'h1F;
  localparam logic [7:0] BYTE_PR_LAST  = 8'h7E;
  localparam logic [7:0] BYTE_MOD_LO   = 8'hE0;
  localparam logic [7:0] BYTE_MOD_HI   = 8'hE7;
  localparam logic [7:0] BYTE_RSV_LO   = 8'hF0;
  localparam logic [7:0] BYTE_RSV_HI   = 8'hFC;
  localparam logic [7:0] BYTE_RAW      = 8'hFD;
  localparam logic [7:0] BYTE_SHORT    = 8'hFE;
  localparam logic [7:0] BYTE_OUTREP   = 8'hFF;
  localparam logic [7:0] KB_LEN        = 8'h09;
  localparam logic [7:0] KB_DESC       = 8'h01;
  localparam logic [7:0] CONS_LEN      = 8'h03;
  localparam logic [7:0] CONS_DESC     = 8'h03;
  localparam logic [7:0] CODE_VKBD     = 8'h65;
  localparam logic [7:0] MOD_LSHIFT    = 8'h02;
  localparam logic [3:0] KB_FRAME_N    = 4'hA;
  localparam logic [3:0] KB_MOD_POS    = 4'h2;
  localparam logic [3:0] KB_CODE_POS   = 4'h4;
  localparam logic [7:0] SH_MAX_IDX    = 8'h06;
  localparam logic [15:0] KEYSUB_RST   = 16'h0000;
  // lock status bit positions in the status byte
  localparam int LOCK_NUM_BIT    = 0;
  localparam int LOCK_CAPS_BIT   = 1;
  localparam int LOCK_SCROLL_BIT = 2;
  // consumer bitmask bit positions
  localparam int CONS_AC_HOME    = 0;
  localparam int CONS_VOL_UP     = 4;
  localparam int CONS_PLAY_PAUSE = 7;
  localparam int CONS_BROWSER    = 15;
  // toggle pin hold time
  localparam int CLK_HZ        = 20000000;
  localparam int TOGGLE_HOLD_MS = 200;
  localparam int TOGGLE_HOLD_CYC = CLK_HZ / 1000 * TOGGLE_HOLD_MS;
  // controller register byte addresses and status/control bit positions
  localparam logic [7:0] ADR_TX     = 8'h00;
  localparam logic [7:0] ADR_RX     = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_KEYSUB = 8'h0C;
  localparam logic [7:0] ADR_CTRL   = 8'h10;
  localparam int ST_TX_BUSY  = 0;
  localparam int ST_RX_FULL  = 1;
  localparam int CTRL_PIN    = 0;
  localparam int CTRL_VKBD   = 1;

  typedef enum {ST_IDLE, ST_RAW_LEN, ST_RAW_DATA, ST_SH_LEN, ST_SH_DATA,
                ST_SEND} uhr_state_t;
  typedef enum {TX_IDLE, TX_CODE, TX_STAT} uhr_tx_t;

  // control byte to scan code; zero means no key
  function automatic logic [7:0] uhr_ctl_code(input logic [7:0] b);
    case (b)
      8'h01: uhr_ctl_code = 8'h49;
      8'h02: uhr_ctl_code = 8'h4A;
      8'h03: uhr_ctl_code = 8'h4B;
      8'h04: uhr_ctl_code = 8'h4C;
      8'h05: uhr_ctl_code = 8'h4D;
      8'h06: uhr_ctl_code = 8'h4E;
      8'h07: uhr_ctl_code = 8'h4F;
      8'h08: uhr_ctl_code = 8'h2A;
      8'h09: uhr_ctl_code = 8'h2B;
      8'h0A: uhr_ctl_code = 8'h28;
      8'h0B: uhr_ctl_code = 8'h50;
      8'h0C: uhr_ctl_code = 8'h51;
      8'h0D: uhr_ctl_code = 8'h28;
      8'h0E: uhr_ctl_code = 8'h52;
      8'h1B: uhr_ctl_code = 8'h29;
      8'h1C: uhr_ctl_code = 8'h39;
      8'h1D: uhr_ctl_code = 8'h47;
      8'h1E: uhr_ctl_code = 8'h48;
      8'h1F: uhr_ctl_code = 8'h53;
      default: uhr_ctl_code = (b >= 8'h0F && b <= 8'h1A) ?
                              8'(b + 8'h2B) : 8'h00;
    endcase
  endfunction

  // printable byte to {shift, scan code}, us layout
  function automatic logic [8:0] uhr_prn_code(input logic [7:0] b);
    if (b >= 8'h61 && b <= 8'h7A) begin
      uhr_prn_code = {1'b0, 8'(b - 8'h5D)};
    end else if (b >= 8'h41 && b <= 8'h5A) begin
      uhr_prn_code = {1'b1, 8'(b - 8'h3D)};
    end else if (b >= 8'h31 && b <= 8'h39) begin
      uhr_prn_code = {1'b0, 8'(b - 8'h13)};
    end else begin
      case (b)
        8'h30: uhr_prn_code = {1'b0, 8'h27};
        8'h20: uhr_prn_code = {1'b0, 8'h2C};
        8'h21: uhr_prn_code = {1'b1, 8'h1E};
        8'h40: uhr_prn_code = {1'b1, 8'h1F};
        8'h23: uhr_prn_code = {1'b1, 8'h20};
        8'h24: uhr_prn_code = {1'b1, 8'h21};
        8'h25: uhr_prn_code = {1'b1, 8'h22};
        8'h5E: uhr_prn_code = {1'b1, 8'h23};
        8'h26: uhr_prn_code = {1'b1, 8'h24};
        8'h2A: uhr_prn_code = {1'b1, 8'h25};
        8'h28: uhr_prn_code = {1'b1, 8'h26};
        8'h29: uhr_prn_code = {1'b1, 8'h27};
        8'h2D: uhr_prn_code = {1'b0, 8'h2D};
        8'h5F: uhr_prn_code = {1'b1, 8'h2D};
        8'h3D: uhr_prn_code = {1'b0, 8'h2E};
        8'h2B: uhr_prn_code = {1'b1, 8'h2E};
        8'h5B: uhr_prn_code = {1'b0, 8'h2F};
        8'h7B: uhr_prn_code = {1'b1, 8'h2F};
        8'h5D: uhr_prn_code = {1'b0, 8'h30};
        8'h7D: uhr_prn_code = {1'b1, 8'h30};
        8'h5C: uhr_prn_code = {1'b0, 8'h31};
        8'h7C: uhr_prn_code = {1'b1, 8'h31};
        8'h3B: uhr_prn_code = {1'b0, 8'h33};
        8'h3A: uhr_prn_code = {1'b1, 8'h33};
        8'h27: uhr_prn_code = {1'b0, 8'h34};
        8'h22: uhr_prn_code = {1'b1, 8'h34};
        8'h60: uhr_prn_code = {1'b0, 8'h35};
        8'h7E: uhr_prn_code = {1'b1, 8'h35};
        8'h2C: uhr_prn_code = {1'b0, 8'h36};
        8'h3C: uhr_prn_code = {1'b1, 8'h36};
        8'h2E: uhr_prn_code = {1'b0, 8'h37};
        8'h3E: uhr_prn_code = {1'b1, 8'h37};
        8'h2F: uhr_prn_code = {1'b0, 8'h38};
        8'h3F: uhr_prn_code = {1'b1, 8'h38};
        default: uhr_prn_code = {1'b0, 8'h00};
      endcase
    end
  endfunction
endpackage
